// ===== logic/lpwm_consts.svh
// Register offsets, field positions, reset values and timing counts of the wake-up monitor.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef LPWM_CONSTS_SVH
`define LPWM_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define LPWM_OFS_CTRL       12'h000
`define LPWM_OFS_STATUS     12'h004
`define LPWM_OFS_CURR_THR   12'h008
`define LPWM_OFS_FILT_PER   12'h00c
`define LPWM_OFS_TRIG_PER   12'h010
`define LPWM_OFS_CHG_THR    12'h014
`define LPWM_OFS_CHG_ACC    12'h018
`define LPWM_OFS_FILT_CNT   12'h01c

// ---------------------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------------------
`define LPWM_CTRL_MODE_LO   0
`define LPWM_CTRL_CRANK_EN  2
`define LPWM_CTRL_THR_WEN   3
`define LPWM_CTRL_CHG_WEN   4
`define LPWM_CTRL_CAL_WEN   5
`define LPWM_CTRL_TEMP_EN   6
`define LPWM_CTRL_ACC_CLR   7
`define LPWM_CTRL_PTB_EN    8

// ---------------------------------------------------------------------------
// Status fields, write one to clear for the four flags
// ---------------------------------------------------------------------------
`define LPWM_ST_UV_WAKE     0
`define LPWM_ST_THR_WAKE    1
`define LPWM_ST_CHG_WAKE    2
`define LPWM_ST_CAL_WAKE    3
`define LPWM_ST_LOW_IRQ     4

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define LPWM_RST_CURR_THR   8'h00
`define LPWM_RST_FILT_PER   8'h01
`define LPWM_RST_TRIG_PER   16'h0064
`define LPWM_RST_CHG_THR    31'h7fffffff

// ---------------------------------------------------------------------------
// Timing: slow tick period and its count at the 20 MHz system clock
// ---------------------------------------------------------------------------
`define LPWM_CLK_HZ         20000000
`define LPWM_SLOW_HZ        1000
`define LPWM_SLOW_DIV       (`LPWM_CLK_HZ / `LPWM_SLOW_HZ)

`endif

// ===== logic/lpwm_pkg.sv
// Types shared by the wake-up monitor.
// Assumes the constants header sits in the include path.
package lpwm_pkg;
  typedef enum logic [1:0] {
    LPWM_OPM_NORMAL,
    LPWM_OPM_STOP,
    LPWM_OPM_SLEEP,
    LPWM_OPM_RSVD
  } lpwm_opm_type;

  typedef enum logic [2:0] {
    LPWM_ST_NORMAL,
    LPWM_ST_STOP,
    LPWM_ST_SLEEP,
    LPWM_ST_CRANK,
    LPWM_ST_INTER
  } lpwm_state_type;
endpackage

// ===== logic/lpwm_monitor.sv
// Wake-up and low-voltage supervision of the battery sensor analog side, with APB registers.
// Assumes synchronous comparator inputs, and an acquisition front end that answers a
// measurement request with a one-cycle done pulse carrying the current and temperature.
//
// Behaviour
// - Raise supply-low interrupt when supply drops below the normal threshold.
// - With cranking enabled, use the cranking threshold for undervoltage detection.
// - Main 5 V regulator off in Sleep, reduced sub-block only in Stop and cranking.
// - Die-link regulator enabled only in Normal mode.
// - Analog supply always on in Normal, in low power only while measuring.
// - Enter cranking on command out of Normal or threshold hit in Stop.
// - Stop commanded below cranking threshold with cranking enabled enters cranking directly.
// - Cranking gates the oscillator, halting any acquisition in progress.
// - Leaving cranking sets the undervoltage wake flag.
// - After cranking exit sit in Intermediate, ignore cranking-enable clears until a Normal, Stop or Sleep write leaves it.
// - Internal wake signal can be routed to a port B pin.
// - Slow-clock counter triggers cyclic current measurements, optional temperature.
// - Cyclic measurement alone never wakes; only enabled wake conditions do.
// - Absolute 24-bit current compared with threshold shifted left by one.
// - Filter counter increments at or above threshold, decrements below.
// - Filter counter reaching period with enable wakes and sets threshold flag.
// - Filter counter cleared on every low-power entry.
// - Signed current added to 32-bit two's complement charge accumulator.
// - Accumulator magnitude at or above 31-bit threshold with enable wakes.
// - Writing one to the clear bit zeroes the accumulator.
// - Accumulation stops after wake until the next Stop or Sleep; accumulator readable anytime in Normal.
// - Out-of-calibration temperature with enable wakes and sets calibration flag.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_consts.svh"

module lpwm_monitor
  import lpwm_pkg::*;
#(
  parameter int unsigned SLOW_DIV = `LPWM_SLOW_DIV
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Supply comparators
  input  wire logic        below_normal_thr_i,
  input  wire logic        below_crank_thr_i,
  // Acquisition front end
  input  wire logic        meas_done_i,
  input  wire logic [23:0] signed_current_result_i,
  input  wire logic        temp_out_of_cal_i,
  output logic             meas_req_o,
  output logic             temp_req_o,
  // Regulators and oscillator
  output logic             main_5v_regulator_o,
  output logic             main_5v_reduced_o,
  output logic             die_link_regulator_o,
  output logic             analog_supply_o,
  output logic             osc_gate_o,
  // Wake and interrupt
  output logic             supply_low_irq_o,
  output logic             wake_signal_output_o,
  output logic             port_b_pin_o
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] abs32(input logic [31:0] v);
    abs32 = v[31] ? 32'(-v) : v;
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  lpwm_state_type state;
  lpwm_state_type next_state;
  logic [1:0]     operating_mode_bits;
  logic           cranking_enable;
  logic           threshold_wake_enable;
  logic           charge_wake_enable;
  logic           calibration_wake_enable;
  logic           temp_enable;
  logic           ptb_route_en;
  logic [7:0]     current_threshold_value;
  logic [7:0]     threshold_filter_period;
  logic [15:0]    cyclic_trigger_period;
  logic [30:0]    charge_threshold;
  logic [31:0]    charge_accumulator;
  logic [7:0]     filt_cnt;
  logic [15:0]    trig_cnt;
  logic [31:0]    slow_div_cnt;
  logic           measuring;
  logic           undervoltage_wake_flag;
  logic           threshold_wake_flag;
  logic           charge_wake_flag;
  logic           calibration_wake_flag;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire        acc_phase  = psel_i & penable_i & pready_o;
  wire        wr         = acc_phase & pwrite_i;
  wire        wr_ctrl    = wr & (paddr_i == `LPWM_OFS_CTRL);
  wire        wr_status  = wr & (paddr_i == `LPWM_OFS_STATUS);
  wire        wr_cthr    = wr & (paddr_i == `LPWM_OFS_CURR_THR);
  wire        wr_fper    = wr & (paddr_i == `LPWM_OFS_FILT_PER);
  wire        wr_tper    = wr & (paddr_i == `LPWM_OFS_TRIG_PER);
  wire        wr_chthr   = wr & (paddr_i == `LPWM_OFS_CHG_THR);
  wire        mapped     = (paddr_i[1:0] == 2'h0) && (paddr_i <= `LPWM_OFS_FILT_CNT);
  wire [1:0]  wr_opm     = pwdata_i[`LPWM_CTRL_MODE_LO +: 2];
  wire        low_power  = (state == LPWM_ST_STOP) || (state == LPWM_ST_SLEEP);

  // ---------------------------------------------------------------------------
  // Supply monitor and mode machine
  // ---------------------------------------------------------------------------
  wire uv_now   = cranking_enable ? below_crank_thr_i : below_normal_thr_i;
  wire stop_cmd = wr_ctrl && (wr_opm == LPWM_OPM_STOP);
  wire slp_cmd  = wr_ctrl && (wr_opm == LPWM_OPM_SLEEP);
  wire nrm_cmd  = wr_ctrl && (wr_opm == LPWM_OPM_NORMAL);
  property p_low_irq; below_normal_thr_i && !cranking_enable |=> supply_low_irq_o; endproperty
  a_low_irq: assert property (p_low_irq) else $error("Supply-low irq missing.");
  property p_crk_thr; cranking_enable && !below_crank_thr_i |=> !supply_low_irq_o; endproperty
  a_crk_thr: assert property (p_crk_thr) else $error("Normal threshold used.");

  // Current threshold path: shifted 8-bit threshold against 24-bit magnitude.
  wire [23:0] cur_abs    = 24'(abs32({{8{signed_current_result_i[23]}},
                                      signed_current_result_i}));
  wire        cur_hit    = cur_abs >= {15'h0000, current_threshold_value, 1'b0};
  wire [31:0] acc_sum    = charge_accumulator +
                           {{8{signed_current_result_i[23]}}, signed_current_result_i};
  wire        cyc_done   = low_power & measuring & meas_done_i;
  wire [7:0]  filt_next  = cur_hit ? ((filt_cnt == 8'hff) ? filt_cnt : 8'(filt_cnt + 8'h01))
                         : ((filt_cnt == 8'h00) ? filt_cnt : 8'(filt_cnt - 8'h01));
  wire        thr_event  = cyc_done && (filt_next >= threshold_filter_period);
  wire        chg_event  = cyc_done && (abs32(acc_sum) >= {1'b0, charge_threshold});
  wire        cal_event  = cyc_done && temp_req_o && temp_out_of_cal_i;
  // Only enabled conditions wake; a bare cyclic result does not.
  wire        wake       = (thr_event & threshold_wake_enable) |
                           (chg_event & charge_wake_enable) |
                           (cal_event & calibration_wake_enable);
  wire        crank_exit = (state == LPWM_ST_CRANK) && !below_crank_thr_i;

  always_comb begin
    next_state = state;
    case (state)
      LPWM_ST_NORMAL, LPWM_ST_INTER: begin
        if (stop_cmd && cranking_enable && below_crank_thr_i) begin
          next_state = LPWM_ST_CRANK;
        end else if (stop_cmd) begin
          next_state = LPWM_ST_STOP;
        end else if (slp_cmd) begin
          next_state = LPWM_ST_SLEEP;
        end else if (nrm_cmd) begin
          next_state = LPWM_ST_NORMAL;
        end
      end
      LPWM_ST_STOP: begin
        if (cranking_enable && below_crank_thr_i) begin
          next_state = LPWM_ST_CRANK;
        end else if (wake) begin
          next_state = LPWM_ST_INTER;
        end
      end
      LPWM_ST_SLEEP: begin
        if (wake) begin
          next_state = LPWM_ST_INTER;
        end
      end
      LPWM_ST_CRANK: begin
        if (crank_exit) begin
          next_state = LPWM_ST_INTER;
        end
      end
      default: next_state = LPWM_ST_NORMAL;
    endcase
  end
  // Only Stop and Sleep entries restart the threshold filter.
  wire lp_entry = !low_power && ((next_state == LPWM_ST_STOP) || (next_state == LPWM_ST_SLEEP));
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= LPWM_ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // A Normal, Stop or Sleep mode write leaves Intermediate, so the cranking enable is only locked there.
  wire crank_locked = (state == LPWM_ST_INTER);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      operating_mode_bits                     <= 2'h0;
      cranking_enable         <= 1'b0;
      threshold_wake_enable   <= 1'b0;
      charge_wake_enable      <= 1'b0;
      calibration_wake_enable <= 1'b0;
      temp_enable             <= 1'b0;
      ptb_route_en            <= 1'b0;
      current_threshold_value <= `LPWM_RST_CURR_THR;
      threshold_filter_period <= `LPWM_RST_FILT_PER;
      cyclic_trigger_period   <= `LPWM_RST_TRIG_PER;
      charge_threshold        <= `LPWM_RST_CHG_THR;
    end else begin
      if (wr_ctrl) begin
        operating_mode_bits                     <= wr_opm;
        cranking_enable         <= pwdata_i[`LPWM_CTRL_CRANK_EN] |
                                   (crank_locked & cranking_enable);
        threshold_wake_enable   <= pwdata_i[`LPWM_CTRL_THR_WEN];
        charge_wake_enable      <= pwdata_i[`LPWM_CTRL_CHG_WEN];
        calibration_wake_enable <= pwdata_i[`LPWM_CTRL_CAL_WEN];
        temp_enable             <= pwdata_i[`LPWM_CTRL_TEMP_EN];
        ptb_route_en            <= pwdata_i[`LPWM_CTRL_PTB_EN];
      end
      if (wr_cthr) current_threshold_value <= pwdata_i[7:0];
      if (wr_fper) threshold_filter_period <= pwdata_i[7:0];
      if (wr_tper) cyclic_trigger_period <= pwdata_i[15:0];
      if (wr_chthr) charge_threshold <= pwdata_i[30:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Cyclic trigger on the calibrated slow tick
  // ---------------------------------------------------------------------------
  // The oscillator gate clears the tick counters and drops any measurement under way.
  wire slow_tick = (slow_div_cnt == 32'(SLOW_DIV - 1));
  wire trig_fire = low_power && slow_tick && (trig_cnt >= cyclic_trigger_period) && !measuring;
  property p_osc_gate; state == LPWM_ST_CRANK |-> osc_gate_o ##1 !measuring; endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("Cranking left oscillator on.");
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slow_div_cnt <= 32'h0;
      trig_cnt     <= 16'h0000;
      measuring    <= 1'b0;
      meas_req_o   <= 1'b0;
      temp_req_o   <= 1'b0;
    end else begin
      meas_req_o <= trig_fire;
      if (!low_power) begin
        slow_div_cnt <= 32'h0;
        trig_cnt     <= 16'h0000;
        measuring    <= 1'b0;
      end else begin
        slow_div_cnt <= slow_tick ? 32'h0 : slow_div_cnt + 32'h1;
        if (trig_fire) begin
          trig_cnt   <= 16'h0000;
          measuring  <= 1'b1;
          temp_req_o <= temp_enable;
        end else begin
          if (slow_tick) trig_cnt <= 16'(trig_cnt + 16'h0001);
          if (meas_done_i) measuring <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Threshold filter and charge accumulator
  // ---------------------------------------------------------------------------
  wire acc_clr = wr_ctrl && pwdata_i[`LPWM_CTRL_ACC_CLR];
  property p_filt_clr; lp_entry |=> filt_cnt == 8'h00; endproperty
  a_filt_clr: assert property (p_filt_clr) else $error("Filter not cleared.");
  property p_acc_clr; acc_clr |=> charge_accumulator == 32'h0; endproperty
  a_acc_clr: assert property (p_acc_clr) else $error("Accumulator not cleared.");
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      filt_cnt           <= 8'h00;
      charge_accumulator <= 32'h0;
    end else begin
      if (lp_entry) filt_cnt <= 8'h00;
      else if (cyc_done) filt_cnt <= filt_next;
      // Accumulation runs only on cyclic results in Stop or Sleep, so a wake stops it; an explicit clear zeroes it.
      if (acc_clr) charge_accumulator <= 32'h0;
      else if (cyc_done) charge_accumulator <= acc_sum;
    end
  end

  // ---------------------------------------------------------------------------
  // Flags: a hardware set wins over a same-cycle write-one clear
  // ---------------------------------------------------------------------------
  wire clr_uv  = wr_status & pwdata_i[`LPWM_ST_UV_WAKE];
  wire clr_thr = wr_status & pwdata_i[`LPWM_ST_THR_WAKE];
  wire clr_chg = wr_status & pwdata_i[`LPWM_ST_CHG_WAKE];
  wire clr_cal = wr_status & pwdata_i[`LPWM_ST_CAL_WAKE];

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      undervoltage_wake_flag <= 1'b0;
      threshold_wake_flag    <= 1'b0;
      charge_wake_flag       <= 1'b0;
      calibration_wake_flag  <= 1'b0;
    end else begin
      undervoltage_wake_flag <= crank_exit | (undervoltage_wake_flag & ~clr_uv);
      threshold_wake_flag    <= (thr_event & threshold_wake_enable) |
                                (threshold_wake_flag & ~clr_thr);
      charge_wake_flag       <= (chg_event & charge_wake_enable) |
                                (charge_wake_flag & ~clr_chg);
      calibration_wake_flag  <= (cal_event & calibration_wake_enable) |
                                (calibration_wake_flag & ~clr_cal);
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  wire [31:0] rd_mux =
    (paddr_i == `LPWM_OFS_CTRL)     ? {23'h0, ptb_route_en, 1'b0, temp_enable,
                                       calibration_wake_enable, charge_wake_enable,
                                       threshold_wake_enable, cranking_enable, operating_mode_bits} :
    (paddr_i == `LPWM_OFS_STATUS)   ? {26'h0, 1'(state), supply_low_irq_o,
                                       calibration_wake_flag, charge_wake_flag,
                                       threshold_wake_flag, undervoltage_wake_flag} :
    (paddr_i == `LPWM_OFS_CURR_THR) ? {24'h0, current_threshold_value} :
    (paddr_i == `LPWM_OFS_FILT_PER) ? {24'h0, threshold_filter_period} :
    (paddr_i == `LPWM_OFS_TRIG_PER) ? {16'h0, cyclic_trigger_period} :
    (paddr_i == `LPWM_OFS_CHG_THR)  ? {1'b0, charge_threshold} :
    (paddr_i == `LPWM_OFS_CHG_ACC)  ? charge_accumulator :
    (paddr_i == `LPWM_OFS_FILT_CNT) ? {24'h0, filt_cnt} : 32'h0;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o             <= 32'h0;
      pready_o             <= 1'b0;
      pslverr_o            <= 1'b0;
      supply_low_irq_o     <= 1'b0;
      main_5v_regulator_o  <= 1'b1;
      main_5v_reduced_o    <= 1'b0;
      die_link_regulator_o <= 1'b1;
      analog_supply_o      <= 1'b1;
      osc_gate_o           <= 1'b0;
      wake_signal_output_o <= 1'b0;
      port_b_pin_o         <= 1'b0;
    end else begin
      // One wait state: pready rises in the second access cycle.
      pready_o             <= psel_i & penable_i & ~pready_o;
      pslverr_o            <= psel_i & penable_i & ~pready_o & ~mapped;
      prdata_o             <= (psel_i & ~pwrite_i & mapped) ? rd_mux : 32'h0;
      supply_low_irq_o     <= uv_now;
      main_5v_regulator_o  <= (next_state == LPWM_ST_NORMAL) ||
                              (next_state == LPWM_ST_INTER);
      main_5v_reduced_o    <= (next_state == LPWM_ST_STOP) ||
                              (next_state == LPWM_ST_CRANK);
      die_link_regulator_o <= (next_state == LPWM_ST_NORMAL);
      analog_supply_o      <= (next_state == LPWM_ST_NORMAL) || (low_power && measuring);
      osc_gate_o           <= (next_state == LPWM_ST_CRANK);
      wake_signal_output_o <= wake | crank_exit;
      port_b_pin_o         <= ptb_route_en & (wake | crank_exit);
    end
  end

  property p_die_link; die_link_regulator_o |-> state == LPWM_ST_NORMAL; endproperty
  a_die_link: assert property (p_die_link) else $error("Die-link on outside Normal.");
endmodule
`default_nettype wire

// ===== testbench/lpwm_acq_model.sv
// Behavioural acquisition front end answering each measurement request.
// Assumes requests are one-cycle pulses; the result is valid only with the done pulse.
`timescale 1ns/1ps
`default_nettype none

module lpwm_acq_model #(
  parameter int DELAY = 3
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Request side
  input  wire logic        meas_req_i,
  input  wire logic [23:0] current_i,
  input  wire logic        out_of_cal_i,
  // Answer side
  output logic             meas_done_o,
  output logic      [23:0] result_o,
  output logic             out_of_cal_o
);
  int cnt;

  // Data lines toggle outside the done pulse, so mistimed sampling sees garbage.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt          <= 0;
      meas_done_o  <= 1'b0;
      result_o     <= 24'h5a5a5a;
      out_of_cal_o <= 1'b0;
    end else begin
      meas_done_o  <= 1'b0;
      result_o     <= ~result_o;
      out_of_cal_o <= ~out_of_cal_o;
      if (meas_req_i) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        cnt          <= 0;
        meas_done_o  <= 1'b1;
        result_o     <= current_i;
        out_of_cal_o <= out_of_cal_i;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== testbench/lpwm_monitor_tb.sv
// Self-checking bench of the wake-up monitor: register access, supply supervision,
// cranking and the cyclic wake conditions.
// Assumes the design sources and the acquisition model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "lpwm_consts.svh"

module lpwm_monitor_tb;
  typedef struct packed {logic [11:0] a; logic [31:0] q; logic e;} lpwm_row_type;
  logic        sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic        below_normal_thr_i, below_crank_thr_i, meas_done_i, temp_out_of_cal_i;
  logic        meas_req_o, temp_req_o, main_5v_regulator_o, main_5v_reduced_o, e, cal_val;
  logic        die_link_regulator_o, analog_supply_o, osc_gate_o, supply_low_irq_o;
  logic        wake_signal_output_o, port_b_pin_o;
  logic [23:0] signed_current_result_i, cur_val;
  int          n_errors = 0, num_checks = 0, wake_cnt = 0, pb_cnt = 0, meas_cnt = 0;
  int          treq_cnt = 0, m;
  lpwm_row_type rows [10] = '{
    '{`LPWM_OFS_CTRL, 32'h0, 1'b0}, '{`LPWM_OFS_STATUS, 32'h0, 1'b0},
    '{`LPWM_OFS_CURR_THR, 32'(`LPWM_RST_CURR_THR), 1'b0},
    '{`LPWM_OFS_FILT_PER, 32'(`LPWM_RST_FILT_PER), 1'b0},
    '{`LPWM_OFS_TRIG_PER, 32'(`LPWM_RST_TRIG_PER), 1'b0},
    '{`LPWM_OFS_CHG_THR, 32'(`LPWM_RST_CHG_THR), 1'b0},
    '{`LPWM_OFS_CHG_ACC, 32'h0, 1'b0}, '{`LPWM_OFS_FILT_CNT, 32'h0, 1'b0},
    '{12'h020, 32'h0, 1'b1}, '{12'h006, 32'h0, 1'b1}};

  lpwm_monitor #(.SLOW_DIV(4)) dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .below_normal_thr_i(below_normal_thr_i),
    .below_crank_thr_i(below_crank_thr_i), .meas_done_i(meas_done_i),
    .signed_current_result_i(signed_current_result_i), .temp_out_of_cal_i(temp_out_of_cal_i),
    .meas_req_o(meas_req_o), .temp_req_o(temp_req_o), .main_5v_regulator_o(main_5v_regulator_o),
    .main_5v_reduced_o(main_5v_reduced_o), .die_link_regulator_o(die_link_regulator_o),
    .analog_supply_o(analog_supply_o), .osc_gate_o(osc_gate_o),
    .supply_low_irq_o(supply_low_irq_o), .wake_signal_output_o(wake_signal_output_o),
    .port_b_pin_o(port_b_pin_o));

  lpwm_acq_model acq (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .meas_req_i(meas_req_o),
    .current_i(cur_val), .out_of_cal_i(cal_val), .meas_done_o(meas_done_i),
    .result_o(signed_current_result_i), .out_of_cal_o(temp_out_of_cal_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (wake_signal_output_o === 1'b1) wake_cnt++;
    if (port_b_pin_o === 1'b1) pb_cnt++;
    if (meas_done_i === 1'b1) meas_cnt++;
    if (meas_req_o === 1'b1 && temp_req_o === 1'b1) treq_cnt++;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; pready is judged by its pre-edge value.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rq = prdata_o;
    re = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wait_wake(output int mc);
    int w0, m0, n;
    w0 = wake_cnt;
    m0 = meas_cnt;
    n  = 0;
    while (wake_cnt == w0 && n < 3000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 3000) n_errors++;
    repeat (2) @(posedge sys_clk_i);
    mc = meas_cnt - m0;
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {below_normal_thr_i, below_crank_thr_i, cur_val, cal_val} = '0;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0, q, e);
      chk(q, rows[i].q);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    chk({27'h0, main_5v_regulator_o, main_5v_reduced_o, die_link_regulator_o,
         analog_supply_o, osc_gate_o}, 32'h16);
    below_normal_thr_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, supply_low_irq_o}, 32'h1);
    apb(1'b1, `LPWM_OFS_CTRL, 32'h4, q, e);
    @(posedge sys_clk_i);
    chk({31'h0, supply_low_irq_o}, 32'h0);
    below_crank_thr_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk({31'h0, supply_low_irq_o}, 32'h1);
    apb(1'b1, `LPWM_OFS_CTRL, 32'h5, q, e);
    chk({28'h0, main_5v_regulator_o, main_5v_reduced_o, die_link_regulator_o,
         osc_gate_o}, 32'h5);
    below_crank_thr_i  <= 1'b0;
    below_normal_thr_i <= 1'b0;
    wait_wake(m);
    apb(1'b0, `LPWM_OFS_STATUS, 32'h0, q, e);
    chk(q & 32'hf, 32'h1);
    apb(1'b1, `LPWM_OFS_CTRL, 32'h3, q, e);
    apb(1'b0, `LPWM_OFS_CTRL, 32'h0, q, e);
    chk(q & 32'h4, 32'h4);
    apb(1'b1, `LPWM_OFS_STATUS, 32'hf, q, e);
    apb(1'b1, `LPWM_OFS_CTRL, 32'h0, q, e);
    chk({31'h0, die_link_regulator_o}, 32'h1);
    apb(1'b1, `LPWM_OFS_CURR_THR, 32'h10, q, e);
    apb(1'b1, `LPWM_OFS_FILT_PER, 32'h2, q, e);
    apb(1'b1, `LPWM_OFS_TRIG_PER, 32'h2, q, e);
    cur_val <= 24'hffffe0;
    apb(1'b1, `LPWM_OFS_CTRL, 32'h109, q, e);
    wait_wake(m);
    chk(32'(m), 32'h2);
    chk(32'(pb_cnt), 32'h1);
    apb(1'b0, `LPWM_OFS_STATUS, 32'h0, q, e);
    chk(q & 32'hf, 32'h2);
    apb(1'b1, `LPWM_OFS_CTRL, 32'h0, q, e);
    apb(1'b0, `LPWM_OFS_CHG_ACC, 32'h0, q, e);
    chk(q, 32'hffffffc0);
    apb(1'b1, `LPWM_OFS_CTRL, 32'h80, q, e);
    apb(1'b0, `LPWM_OFS_CHG_ACC, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, `LPWM_OFS_STATUS, 32'hf, q, e);
    apb(1'b1, `LPWM_OFS_CHG_THR, 32'h40, q, e);
    cur_val <= 24'h000020;
    apb(1'b1, `LPWM_OFS_CTRL, 32'h11, q, e);
    wait_wake(m);
    chk(32'(m), 32'h2);
    apb(1'b0, `LPWM_OFS_STATUS, 32'h0, q, e);
    chk(q & 32'hf, 32'h4);
    apb(1'b0, `LPWM_OFS_FILT_CNT, 32'h0, q, e);
    chk(q, 32'h2);
    apb(1'b1, `LPWM_OFS_STATUS, 32'hf, q, e);
    cur_val <= 24'h000000;
    cal_val <= 1'b1;
    apb(1'b1, `LPWM_OFS_CTRL, 32'h61, q, e);
    wait_wake(m);
    chk(32'(m), 32'h1);
    chk(32'(treq_cnt), 32'h1);
    apb(1'b0, `LPWM_OFS_STATUS, 32'h0, q, e);
    chk(q & 32'hf, 32'h8);
    apb(1'b0, `LPWM_OFS_FILT_CNT, 32'h0, q, e);
    chk(q, 32'h0);
    summarize();
  end

  // Whole run is a few hundred cycles; this limit of 20000 cycles leaves ample margin.
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
endmodule

`default_nettype wire
